// [hw/chi_regs.vh]
// Constants for the charger serial-port host controller.
// Included by the controller; holds definitions only.
`ifndef CHI_REGS_VH
`define CHI_REGS_VH
`define CHI_DEV_ADDR 7'h6B
`define CHI_REG_CHARGE_OPTION0 8'h00
`define CHI_REG_CHARGE_CURRENT 8'h02
`define CHI_REG_CHARGE_VOLTAGE 8'h04
`define CHI_REG_REVERSE_VOLTAGE 8'h06
`define CHI_REG_INPUT_VOLTAGE 8'h0A
`define CHI_REG_INPUT_LIMIT 8'h0E
`define CHI_REG_CHARGER_STATUS 8'h20
`define CHI_REG_THROTTLE_STATUS 8'h22
`define CHI_REG_CHARGE_OPTION1 8'h30
`define CHI_REG_CHARGE_OPTION2 8'h32
`define CHI_REG_CHARGE_OPTION3 8'h34
`define CHI_REG_THROTTLE_OPTION0 8'h36
`define CHI_REG_THROTTLE_OPTION1 8'h38
`define CHI_REG_SAMPLING_OPTION 8'h3A
`define CHI_RST_CHARGE_OPTION0 16'hE20E
`define CHI_RST_CHARGE_OPTION1 16'h0211
`define CHI_RST_CHARGE_OPTION2 16'h02B7
`define CHI_RST_CHARGE_OPTION3 16'h0000
`define CHI_RST_THROTTLE_OPTION0 16'h4A54
`define CHI_RST_THROTTLE_OPTION1 16'h8120
`define CHI_RST_SAMPLING_OPTION 16'h2000
`define CHI_LOW_POWER_BIT 15
`define CHI_WATCHDOG_MSB 14
`define CHI_WATCHDOG_LSB 13
`define CHI_CLK_MHZ 200
`define CHI_STD_KHZ 100
`define CHI_FAST_KHZ 400
// Quarter bit period in sys_clk cycles, rounded up so the bus rate never exceeds its limit
`define CHI_QUARTER_STD ((`CHI_CLK_MHZ * 1000 + 4 * `CHI_STD_KHZ - 1) / (4 * `CHI_STD_KHZ))
`define CHI_QUARTER_FAST ((`CHI_CLK_MHZ * 1000 + 4 * `CHI_FAST_KHZ - 1) / (4 * `CHI_FAST_KHZ))
`endif

// [hw/chi_host.v]
// Host controller for a two-wire charger slave: issues word writes and word reads.
// Assumes external pull-ups on both lines and a device address fixed by the device.
// Commands wait for both lines to read high, so a busy bus delays the start.
// Behaviour
// R1: Device answers at fixed seven-bit address.
// R2: Word transfers: register address then two bytes.
// R3: Bus runs at standard or fast rate.
// R4: Lines only pulled low or released.
// R5: Data changes only while clock low.
// R6: Start and stop are data edges, clock high.
// R7: Master makes start/stop; busy until stop.
// R8: Bytes are eight bits, MSB first.
// R9: Wait while slave holds clock low.
// R10: Ninth pulse carries acknowledge from receiver.
// R11: No acknowledge ends with stop.
// R12: First byte is address plus direction.
// R13: Device refuses undefined register addresses.
// R14: Device serves multi-byte transfers.
// R15: Setpoint written low byte then high byte.
// R16: Device commits setpoint bytes together.
// R17: High byte first is discarded.
// R18: Long gap between bytes discards both.
// R19: Device holds constant maker code.
// R20: Result registers in fixed order.
// R21: Converter off in low power mode.
// R22: Enabling converter on battery leaves low power.
// R23: Watchdog field at upper option bits 6:5.
// R24: Low power is upper option bit 7.
// R25: Throttle status clears after read, inactive.
// R26: Mismatched address left unacknowledged.
`include "chi_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module chi_host
(
    input wire sys_clk,
    input wire reset_n,
    input wire cmd_valid,
    input wire cmd_read,
    input wire [7:0] cmd_reg,
    input wire [15:0] cmd_data,
    input wire fast_mode,
    output reg cmd_ready,
    output reg done,
    output reg nack,
    output reg [15:0] rd_data,
    input wire scl_in,
    output reg scl_out,
    output reg scl_oe,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe
);
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_START = 4'h1;
    localparam [3:0] ST_BIT = 4'h2;
    localparam [3:0] ST_ACK = 4'h3;
    localparam [3:0] ST_RSTART = 4'h4;
    localparam [3:0] ST_STOP = 4'h5;
    localparam [15:0] QSTD = `CHI_QUARTER_STD;
    localparam [15:0] QFAST = `CHI_QUARTER_FAST;

    reg scl_meta;
    reg scl_s;
    reg sda_meta;
    reg sda_s;
    reg [3:0] state;
    reg [1:0] phase;
    reg [15:0] tick_cnt;
    reg [2:0] bit_idx;
    reg [2:0] byte_idx;
    reg [7:0] shreg;
    reg is_read;
    reg [7:0] reg_addr;
    reg [15:0] wdata;
    reg rd_byte;
    reg got_ack;

    wire tick = (tick_cnt == 16'h0000);
    // Keep fast_mode steady in a transfer: it retimes the very next quarter
    wire [15:0] quarter = fast_mode ? QFAST : QSTD; // [R3]
    // Write: addr/W, reg, low, high. Read: addr/W, reg, rstart, addr/R, low, high
    wire [7:0] next_tx_byte = (byte_idx == 3'h0) ? {`CHI_DEV_ADDR, 1'b0} : // [R1] [R12]
                              (byte_idx == 3'h1) ? reg_addr :
                              (byte_idx == 3'h2) ? (is_read ? {`CHI_DEV_ADDR, 1'b1} : wdata[7:0]) : // [R15]
                              wdata[15:8];
    // After an ack the index still names the byte just sent, so look one ahead
    wire [7:0] next_data_byte = (byte_idx == 3'h0) ? reg_addr :
                                (byte_idx == 3'h1) ? wdata[7:0] :
                                wdata[15:8];

    // Two-flop synchronisers; both lines come from off-chip
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            scl_meta <= 1'b1;
            scl_s <= 1'b1;
            sda_meta <= 1'b1;
            sda_s <= 1'b1;
        end
        else
        begin
            scl_meta <= scl_in;
            scl_s <= scl_meta;
            sda_meta <= sda_in;
            sda_s <= sda_meta;
        end
    end

    // Quarter-period divider; its one-cycle tick paces every line change
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            tick_cnt <= 16'h0000;
        else if (tick || state == ST_IDLE)
            tick_cnt <= quarter - 16'h0001;
        // Released clock still low in the high quarter: slave stretches, or the
        // synchroniser has not caught up yet; both mean wait
        else if (!(phase == 2'h2 && scl_out && !scl_s))
            tick_cnt <= tick_cnt - 16'h0001; // Frozen while slave stretches [R9]
    end

    // Bit engine: q0 data, q1 clock up, q2 sample, q3 clock down
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_IDLE;
            phase <= 2'h0;
            bit_idx <= 3'h7;
            byte_idx <= 3'h0;
            shreg <= 8'hFF;
            is_read <= 1'b0;
            reg_addr <= 8'h00;
            wdata <= 16'h0000;
            rd_byte <= 1'b0;
            got_ack <= 1'b0;
            cmd_ready <= 1'b0;
            done <= 1'b0;
            nack <= 1'b0;
            rd_data <= 16'h0000;
            scl_out <= 1'b1;
            scl_oe <= 1'b0;
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state)
            ST_IDLE:
            begin
                scl_oe <= 1'b0;
                sda_oe <= 1'b0;
                scl_out <= 1'b1;
                sda_out <= 1'b1;
                // Bus counts as busy until both lines read high [R7]
                cmd_ready <= scl_s && sda_s;
                if (cmd_valid && cmd_ready)
                begin
                    cmd_ready <= 1'b0;
                    is_read <= cmd_read;
                    reg_addr <= cmd_reg;
                    wdata <= cmd_data;
                    byte_idx <= 3'h0;
                    nack <= 1'b0;
                    phase <= 2'h0;
                    state <= ST_START;
                end
            end
            ST_START:
                if (tick)
                begin
                    // Data falls with clock high [R6] [R7]
                    sda_out <= 1'b0;
                    sda_oe <= 1'b1; // [R4]
                    phase <= phase + 2'h1;
                    if (phase == 2'h1)
                    begin
                        scl_out <= 1'b0;
                        scl_oe <= 1'b1;
                        shreg <= next_tx_byte;
                        rd_byte <= 1'b0;
                        bit_idx <= 3'h7;
                        phase <= 2'h0;
                        state <= ST_BIT;
                    end
                end
            ST_BIT, ST_ACK:
                if (tick)
                begin
                    phase <= phase + 2'h1;
                    case (phase)
                    2'h0:
                    begin
                        // Data moves only in the low phase [R5]
                        if (state == ST_BIT)
                        begin
                            sda_out <= rd_byte ? 1'b1 : shreg[7]; // [R8]
                            sda_oe <= rd_byte ? 1'b0 : !shreg[7];
                        end
                        else
                        begin
                            // Host acks the low data byte, nacks the last [R10]
                            sda_out <= !(rd_byte && byte_idx == 3'h3);
                            sda_oe <= rd_byte && byte_idx == 3'h3;
                        end
                    end
                    2'h1:
                    begin
                        scl_out <= 1'b1;
                        scl_oe <= 1'b0;
                    end
                    // Mid-high sample, clear of both clock edges
                    2'h2:
                        if (state == ST_BIT)
                            shreg <= {shreg[6:0], sda_s};
                        else
                            got_ack <= !sda_s;
                    default:
                    begin
                        scl_out <= 1'b0;
                        scl_oe <= 1'b1;
                        if (state == ST_BIT)
                        begin
                            bit_idx <= bit_idx - 3'h1;
                            if (bit_idx == 3'h0)
                                state <= ST_ACK;
                        end
                        else if (rd_byte)
                        begin
                            // Low byte arrives first [R2]
                            if (byte_idx == 3'h3)
                                rd_data[7:0] <= shreg;
                            else
                                rd_data[15:8] <= shreg;
                            byte_idx <= byte_idx + 3'h1;
                            if (byte_idx == 3'h4)
                            begin
                                done <= 1'b1;
                                state <= ST_STOP;
                            end
                            else
                            begin
                                shreg <= 8'hFF;
                                bit_idx <= 3'h7;
                                state <= ST_BIT;
                            end
                        end
                        else if (!got_ack)
                        begin
                            nack <= 1'b1; // [R11] [R13] [R26]
                            done <= 1'b1;
                            state <= ST_STOP;
                        end
                        else if (is_read && byte_idx == 3'h1)
                        begin
                            byte_idx <= 3'h2;
                            state <= ST_RSTART;
                        end
                        else if (is_read && byte_idx == 3'h2)
                        begin
                            byte_idx <= 3'h3;
                            rd_byte <= 1'b1;
                            shreg <= 8'hFF;
                            bit_idx <= 3'h7;
                            state <= ST_BIT;
                        end
                        else if (byte_idx == 3'h3)
                        begin
                            done <= 1'b1; // Both setpoint bytes sent back to back [R2] [R16]
                            state <= ST_STOP;
                        end
                        else
                        begin
                            byte_idx <= byte_idx + 3'h1;
                            shreg <= next_data_byte;
                            bit_idx <= 3'h7;
                            state <= ST_BIT;
                        end
                    end
                    endcase
                end
            ST_RSTART:
                if (tick)
                begin
                    phase <= phase + 2'h1;
                    case (phase)
                    2'h0:
                    begin
                        sda_out <= 1'b1;
                        sda_oe <= 1'b0;
                    end
                    2'h1:
                    begin
                        scl_out <= 1'b1;
                        scl_oe <= 1'b0;
                    end
                    default:
                    begin
                        // Full start again: data falls first, clock one quarter later [R6]
                        phase <= 2'h0;
                        state <= ST_START;
                    end
                    endcase
                end
            default:
                if (tick)
                begin
                    // Stop: data rises with clock high [R6]
                    phase <= phase + 2'h1;
                    case (phase)
                    2'h0:
                    begin
                        sda_out <= 1'b0;
                        sda_oe <= 1'b1;
                    end
                    2'h1:
                    begin
                        scl_out <= 1'b1;
                        scl_oe <= 1'b0;
                    end
                    // Reached only once the clock reads high, so a stretch delays it
                    2'h2:
                    begin
                        sda_out <= 1'b1;
                        sda_oe <= 1'b0;
                    end
                    default:
                    begin
                        phase <= 2'h0;
                        state <= ST_IDLE;
                    end
                    endcase
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [bench/chi_host_asserts.sv]
// Port checker for the charger host controller.
// Bound to chi_host; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module chi_host_asserts
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_reg,
    input wire logic [15:0] cmd_data,
    input wire logic fast_mode,
    input wire logic cmd_ready,
    input wire logic done,
    input wire logic nack,
    input wire logic [15:0] rd_data,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    wire take = cmd_valid && cmd_ready;
    logic sda_oe_q;
    logic [11:0] stop_wait;
    // Cycles since done until data is released with the clock high
    always @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sda_oe_q <= 1'b0;
            stop_wait <= 12'h000;
        end
        else
        begin
            sda_oe_q <= sda_oe;
            if (done)
                stop_wait <= 12'h001;
            else if (stop_wait != 12'h000 && stop_wait != 12'hFFF && !(sda_oe_q && !sda_oe && !scl_oe))
                stop_wait <= stop_wait + 12'h001;
            else if (stop_wait != 12'hFFF)
                stop_wait <= 12'h000;
        end
    end
    a_open_drain: assert property ((scl_out == !scl_oe) && (sda_out == !sda_oe))
        else $error("line driven high");
    a_start_after_take: assert property (take |-> ##[120:510] ($rose(sda_oe) && !scl_oe))
        else $error("no start");
    a_stop_after_done: assert property (stop_wait < 12'h7D0)
        else $error("no stop");
    a_done_one_cycle: assert property (done |=> !done)
        else $error("done too long");
    a_take_drops_ready: assert property (take |=> !cmd_ready [*8])
        else $error("ready during transfer");
    a_nack_with_done: assert property ($rose(nack) |-> done)
        else $error("nack without done");
    a_rdata_busy_only: assert property ($changed(rd_data) |-> !cmd_ready)
        else $error("read data moved while idle");
    a_idle_bus_free: assert property (cmd_ready |-> !scl_oe && !sda_oe)
        else $error("line held while idle");
    a_stretch_holds: assert property (!scl_oe && !scl_in |-> $stable(sda_oe))
        else $error("data moved while stretched");
    cover property (take && cmd_read);
    cover property (take && !fast_mode);
    cover property ($rose(nack));
    cover property (!scl_oe && !scl_in);
endmodule
bind chi_host chi_host_asserts i_chi_host_asserts (.sys_clk, .reset_n, .cmd_valid, .cmd_read, .cmd_reg, .cmd_data,
    .fast_mode, .cmd_ready, .done, .nack, .rd_data, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe);
`default_nettype wire

// [bench/chi_dev_model.sv]
// Behavioural charger slave: byte register map, paired setpoints, optional stretching.
// Assumes wired-AND lines with pull-ups outside; outputs are pull-low enables.
`timescale 1ns/1ps
`default_nettype none
`include "chi_regs.vh"
module chi_dev_model
#(
    parameter logic [7:0] MAKER_REG = 8'hFE, // Arbitrary placement
    parameter logic [15:0] ID_WORD = 16'h3C5A, // Arbitrary value
    parameter real WDOG_GAP_NS = 175.0e9,
    parameter int ADC_EN_BIT = 7, // Arbitrary placement
    parameter logic [7:0] RESULT_BASE = 8'h40 // Arbitrary placement
)
(
    input wire logic scl,
    input wire logic sda,
    input wire logic stretch,
    output logic scl_oe,
    output logic sda_oe
);
    logic [7:0] mem [256];
    bit known [256];
    logic [7:0] ptr, pend_at, low_byte;
    bit pend;
    realtime pend_t;
    logic [7:0] wa [15] = '{8'h00, 8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3A,
        8'h02, 8'h04, 8'h06, 8'h0A, 8'h0E, 8'h20, 8'h22, MAKER_REG};
    logic [15:0] wv [15] = '{`CHI_RST_CHARGE_OPTION0, `CHI_RST_CHARGE_OPTION1, `CHI_RST_CHARGE_OPTION2,
        `CHI_RST_CHARGE_OPTION3, `CHI_RST_THROTTLE_OPTION0, `CHI_RST_THROTTLE_OPTION1,
        `CHI_RST_SAMPLING_OPTION, 0, 0, 0, 0, 0, 0, 0, ID_WORD};
    task automatic get_bit(output int r);
        @(posedge scl);
        r = sda;
        @(negedge scl or sda);
        if (scl)
            r = sda ? 3 : 2; // Edge with clock high: 3 stop, 2 start
    endtask
    task automatic get_byte(output int c, output logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            get_bit(c);
            if (c > 1)
                return;
            b = {b[6:0], c[0]};
        end
    endtask
    task automatic ack_slot(input bit yes, input bit nxt);
        sda_oe = yes;
        @(posedge scl);
        @(negedge scl);
        sda_oe = nxt; // First read bit set before the stretch ends
        if (stretch)
        begin
            scl_oe = 1;
            #3000;
            scl_oe = 0;
        end
    endtask
    task automatic store(input logic [7:0] a, input logic [7:0] v);
        // Pair expires after the watchdog gap unless the field is zero
        if (pend && pend_at + 8'd1 == a && (mem[8'h01][6:5] == 2'b00 || $realtime - pend_t <= WDOG_GAP_NS))
            {mem[a], mem[pend_at]} = {v, low_byte};
        else if (!(a inside {[8'h02:8'h07], 8'h0A, 8'h0B, 8'h0E, 8'h0F, [8'h20:8'h23], MAKER_REG, MAKER_REG + 8'd1}))
            mem[a] = v; // Lone high byte and read-only words kept
        pend = a inside {8'h02, 8'h04, 8'h06, 8'h0A, 8'h0E};
        pend_at = a;
        low_byte = v;
        pend_t = $realtime;
        // Battery-only model: turning the converter on ends low power
        if (a == 8'h3B && v[ADC_EN_BIT])
            mem[8'h01][7] = 1'b0;
        if (a == 8'h01 && v[7])
            mem[8'h3B][ADC_EN_BIT] = 1'b0; // Converter off in low power
    endtask
    task automatic serve(output bit again);
        int c;
        bit ok;
        logic [7:0] b;
        get_byte(c, b);
        if (c < 2 && b[7:1] == `CHI_DEV_ADDR) // Other addresses left unanswered
        begin
            ack_slot(1, b[0] && !mem[ptr][7]);
            if (b[0])
                do
                begin
                    for (int i = 7; i >= 0; i--)
                    begin
                        sda_oe = !mem[ptr][i]; // Moves only with clock low
                        @(posedge scl);
                        @(negedge scl);
                    end
                    sda_oe = 0;
                    if (ptr inside {8'h22, 8'h23})
                        mem[ptr] = 8'h00; // Read clears; no event stays active here
                    ptr++;
                    get_bit(c);
                end
                while (c == 0);
            else
            begin
                get_byte(c, ptr);
                ok = known[ptr];
                if (c < 2)
                    ack_slot(ok, 0);
                while (c < 2 && ok)
                begin
                    get_byte(c, b);
                    if (c < 2)
                    begin
                        store(ptr, b);
                        ack_slot(1, 0);
                        ptr++;
                    end
                end
            end
        end
        while (c < 2)
            get_bit(c);
        again = c == 2;
    endtask
    initial
    begin
        bit again;
        scl_oe = 0;
        sda_oe = 0;
        pend = 0;
        foreach (mem[i])
            mem[i] = 0;
        foreach (wa[i])
        begin
            {mem[wa[i] + 8'd1], mem[wa[i]]} = wv[i];
            known[wa[i]] = 1;
            known[wa[i] + 8'd1] = 1;
        end
        for (int i = 0; i < 8; i++)
        begin
            mem[RESULT_BASE + 8'(i)] = 8'(i + 1); // Battery, system, chg, dischg, input, power, bus, cmp
            known[RESULT_BASE + 8'(i)] = 1;
        end
        forever
        begin
            @(negedge sda iff scl === 1'b1); // Busy until stop
            do
                serve(again);
            while (again);
        end
    end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Bench for the charger host controller against a behavioural slave.
// Both lines are wired-AND with pull-ups here.
`timescale 1ns/1ps
`default_nettype none
`include "chi_regs.vh"
module testbench;
    logic sys_clk, reset_n, cmd_valid, cmd_read, fast_mode, stretch;
    logic [7:0] cmd_reg;
    logic [15:0] cmd_data, d;
    wire cmd_ready, done, nack, scl_out, scl_oe, sda_out, sda_oe, dev_scl_oe, dev_sda_oe;
    wire [15:0] rd_data;
    wire scl = !(scl_oe || dev_scl_oe);
    wire sda = !(sda_oe || dev_sda_oe);
    int err_total, comparisons;
    int exp_mem [int];
    logic [7:0] opt_regs [7] = '{8'h00, 8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3A};
    chi_host i_chi_host (.sys_clk, .reset_n, .cmd_valid, .cmd_read, .cmd_reg, .cmd_data, .fast_mode, .cmd_ready,
        .done, .nack, .rd_data, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe);
    chi_dev_model i_chi_dev_model (.scl, .sda, .stretch, .scl_oe(dev_scl_oe), .sda_oe(dev_sda_oe));
    initial
    begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        comparisons++;
        if (got !== want)
        begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic rd, input logic fm, input logic [7:0] r, input logic [15:0] v);
        int n;
        bit ok;
        ok = exp_mem.exists(r);
        n = 0;
        while (cmd_ready !== 1'b1 && n++ < 5000)
            @(negedge sys_clk);
        fast_mode = fm;
        cmd_valid = 1;
        cmd_read = rd;
        cmd_reg = r;
        cmd_data = v;
        @(negedge sys_clk);
        cmd_valid = 0;
        n = 0;
        while (done !== 1'b1 && n++ < 60000)
            @(negedge sys_clk);
        check({15'h0, done}, 16'h1);
        check({15'h0, nack}, {15'h0, !ok});
        if (rd)
            check(rd_data, 16'(exp_mem[r]));
        else if (ok)
            exp_mem[r] = v;
    endtask
    initial
    begin
        #800000;
        err_total++;
        $display("[ERR] %0t timeout", $time);
        stop_test();
    end
    initial
    begin
        err_total = 0;
        comparisons = 0;
        {cmd_valid, cmd_read, cmd_reg, cmd_data} = '0;
        fast_mode = 1;
        stretch = 0;
        reset_n = 0;
        exp_mem = '{8'h00: `CHI_RST_CHARGE_OPTION0, 8'h30: `CHI_RST_CHARGE_OPTION1, 8'h32: `CHI_RST_CHARGE_OPTION2,
            8'h34: `CHI_RST_CHARGE_OPTION3, 8'h36: `CHI_RST_THROTTLE_OPTION0, 8'h38: `CHI_RST_THROTTLE_OPTION1,
            8'h3A: `CHI_RST_SAMPLING_OPTION, 8'h02: 0, 8'h04: 0, 8'h20: 0, 8'h22: 0};
        d = 16'($urandom(29744));
        repeat (20) @(negedge sys_clk);
        reset_n = 1;
        check({14'h0, scl, sda}, 16'h3);
        xfer(1, 1, opt_regs[$urandom % 7], 0);
        stretch = 1;
        xfer(0, 1, `CHI_REG_CHARGE_CURRENT, d);
        xfer(1, 1, `CHI_REG_CHARGE_CURRENT, 0);
        stretch = 0;
        xfer(0, 0, 8'h10, d);
        stop_test();
    end
endmodule
`default_nettype wire
